// [pkg/svo_pkg.sv]
/*
 * Shared constants for the servo command and status I/O logic: pulse format
 * codes, pin positions in the synchroniser vector, widths and reset values.
 * Assumes a single core clock domain; all pin levels arrive asynchronously.
 */
package svo_pkg;

    // ------------------------------------------------------------------
    // command pulse formats
    // ------------------------------------------------------------------
    localparam logic [1:0] SVO_FMT_PULSE_SIGN = 2'h0;
    localparam logic [1:0] SVO_FMT_FWD_REV = 2'h1;
    localparam logic [1:0] SVO_FMT_QUAD = 2'h2;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int SVO_PARAM_W = 16;
    localparam int SVO_DEV_W = 32;

    // ------------------------------------------------------------------
    // bit positions in the pin synchroniser vector
    // ------------------------------------------------------------------
    localparam int SVO_PIN_ENABLE = 0;
    localparam int SVO_PIN_ALM_CLR = 1;
    localparam int SVO_PIN_FWD_INH = 2;
    localparam int SVO_PIN_REV_INH = 3;
    localparam int SVO_PIN_DEV_CLR = 4;
    localparam int SVO_PIN_PULSE_INH = 5;
    localparam int SVO_PIN_GEAR_SEL = 6;
    localparam int SVO_PIN_CMD_PULSE = 7;
    localparam int SVO_PIN_CMD_SIGN = 8;
    localparam int SVO_PIN_ENC_A = 9;
    localparam int SVO_PIN_ENC_B = 10;
    localparam int SVO_PIN_ENC_Z = 11;
    localparam int SVO_PIN_COUNT = 12;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [SVO_PIN_COUNT-1:0] SVO_SYNC_RESET = 12'h000;
    localparam logic [SVO_DEV_W-1:0] SVO_DEV_RESET = 32'h0000_0000;
    localparam logic [SVO_PARAM_W-1:0] SVO_ACC_RESET = 16'h0000;
    localparam logic [1:0] SVO_QUAD_RESET = 2'h0;
    localparam logic [1:0] SVO_PAIR_RESET = 2'h0;

endpackage

// [src/svo_pulse_decode.sv]
/*
 * Decoder for one pulse pair: turns two synchronised levels into a one-cycle
 * step strobe and a direction bit, in any of the three pulse formats.
 * Assumes ch_a and ch_b are already synchronised to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module svo_pulse_decode
    import svo_pkg::*;
(
    input wire logic core_clk,
    input wire logic alarm_clear_in_n,
    input wire logic [1:0] format_sel,
    input wire logic ch_a,
    input wire logic ch_b,
    output logic step,
    output logic dir_fwd
);

    logic [1:0] prev_r;
    logic [1:0] prev_nxt;
    logic [1:0] pos_now;
    logic [1:0] pos_old;
    logic [1:0] pos_diff;

    // ------------------------------------------------------------------
    // decode the pair per format
    // ------------------------------------------------------------------
    always_comb begin
        prev_nxt = {ch_a, ch_b};
        pos_now = {ch_a, ch_a ^ ch_b};
        pos_old = {prev_r[1], prev_r[1] ^ prev_r[0]};
        pos_diff = pos_now - pos_old;
        step = 1'b0;
        dir_fwd = 1'b0;
        case (format_sel)
            SVO_FMT_PULSE_SIGN: begin
                step = ch_a & ~prev_r[1];
                dir_fwd = ch_b; // sign high means forward
            end
            SVO_FMT_FWD_REV: begin
                // simultaneous edges on both lines cancel out
                step = (ch_a & ~prev_r[1]) ^ (ch_b & ~prev_r[0]);
                dir_fwd = ch_a & ~prev_r[1];
            end
            SVO_FMT_QUAD: begin
                // x4 decoding; a two-state jump is illegal and dropped
                step = (pos_diff == 2'h1) || (pos_diff == 2'h3);
                dir_fwd = (pos_diff == 2'h1);
            end
            default: begin
                step = 1'b0;
                dir_fwd = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge alarm_clear_in_n) begin
        if (!alarm_clear_in_n) begin
            prev_r <= SVO_PAIR_RESET;
        end else begin
            prev_r <= prev_nxt;
        end
    end

endmodule
`default_nettype wire

// [src/svo_io_logic.sv]
/*
 * Servo drive command and status I/O: synchronises the controller's function
 * inputs and command pulses, keeps the position deviation counter, and drives
 * in-position, hold/brake, alarm, index and divided encoder echo outputs.
 * Assumes alarm_event_in and all *_param inputs come from core_clk logic.
 */
`timescale 1ns/1ps
`default_nettype none
module svo_io_logic
    import svo_pkg::*;
#(
    parameter int PARAM_W = SVO_PARAM_W,
    parameter int DEV_W = SVO_DEV_W
) (
    input wire logic core_clk,
    input wire logic alarm_clear_in_n,
    input wire logic servo_enable_in,
    input wire logic alarm_clear_in,
    input wire logic forward_inhibit_in,
    input wire logic reverse_inhibit_in,
    input wire logic deviation_clear_in,
    input wire logic pulse_inhibit_in,
    input wire logic gear_select_in,
    input wire logic command_pulse_in,
    input wire logic command_sign_in,
    input wire logic encoder_a_in,
    input wire logic encoder_b_in,
    input wire logic encoder_z_in,
    input wire logic alarm_event_in,
    input wire logic [1:0] pulse_format_param,
    input wire logic [PARAM_W-1:0] primary_gear_param,
    input wire logic [PARAM_W-1:0] alternate_gear_param,
    input wire logic [PARAM_W-1:0] in_position_param,
    input wire logic [PARAM_W-1:0] encoder_divider_a_param,
    input wire logic [PARAM_W-1:0] encoder_divider_b_param,
    output logic drive_enable_out,
    output logic forward_motion_ok_out,
    output logic reverse_motion_ok_out,
    output logic in_position_out,
    output logic hold_brake_out,
    output logic alarm_ok_out,
    output logic index_open_collector_out,
    output logic encoder_a_out,
    output logic encoder_b_out,
    output logic encoder_index_out,
    output logic signed [DEV_W-1:0] deviation_out
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [SVO_PIN_COUNT-1:0] pin_raw;
    logic [SVO_PIN_COUNT-1:0] sync1_r;
    logic [SVO_PIN_COUNT-1:0] sync2_r;

    assign pin_raw = {encoder_z_in, encoder_b_in, encoder_a_in, command_sign_in, command_pulse_in,
                      gear_select_in, pulse_inhibit_in, deviation_clear_in, reverse_inhibit_in,
                      forward_inhibit_in, alarm_clear_in, servo_enable_in};

    // two flops per pin; only sync2_r is read by logic
    genvar gi;
    generate
        for (gi = 0; gi < SVO_PIN_COUNT; gi++) begin : g_sync
            always_ff @(posedge core_clk or negedge alarm_clear_in_n) begin
                if (!alarm_clear_in_n) begin
                    sync1_r[gi] <= SVO_SYNC_RESET[gi];
                    sync2_r[gi] <= SVO_SYNC_RESET[gi];
                end else begin
                    sync1_r[gi] <= pin_raw[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate

    logic en_s, clr_s, fwd_s, rev_s, dclr_s, inh_s, gear_s, z_s;
    assign en_s = sync2_r[SVO_PIN_ENABLE];
    assign clr_s = sync2_r[SVO_PIN_ALM_CLR];
    assign fwd_s = sync2_r[SVO_PIN_FWD_INH];
    assign rev_s = sync2_r[SVO_PIN_REV_INH];
    assign dclr_s = sync2_r[SVO_PIN_DEV_CLR];
    assign inh_s = sync2_r[SVO_PIN_PULSE_INH];
    assign gear_s = sync2_r[SVO_PIN_GEAR_SEL];
    assign z_s = sync2_r[SVO_PIN_ENC_Z];

    // ------------------------------------------------------------------
    // pulse decoders: command pair in the chosen format, feedback as quadrature
    // ------------------------------------------------------------------
    logic cmd_step, cmd_fwd, fb_step, fb_fwd;

    svo_pulse_decode u_cmd_dec (
        .core_clk(core_clk),
        .alarm_clear_in_n(alarm_clear_in_n),
        .format_sel(pulse_format_param),
        .ch_a(sync2_r[SVO_PIN_CMD_PULSE]),
        .ch_b(sync2_r[SVO_PIN_CMD_SIGN]),
        .step(cmd_step),
        .dir_fwd(cmd_fwd)
    );

    svo_pulse_decode u_fb_dec (
        .core_clk(core_clk),
        .alarm_clear_in_n(alarm_clear_in_n),
        .format_sel(SVO_FMT_QUAD),
        .ch_a(sync2_r[SVO_PIN_ENC_A]),
        .ch_b(sync2_r[SVO_PIN_ENC_B]),
        .step(fb_step),
        .dir_fwd(fb_fwd)
    );

    // ------------------------------------------------------------------
    // alarm latch and status outputs
    // ------------------------------------------------------------------
    logic alarm_r, alarm_nxt, clr_prev_r, clr_fall;
    logic drive_r, drive_nxt, fwd_ok_r, fwd_ok_nxt, rev_ok_r, rev_ok_nxt;
    logic hold_r, hold_nxt, alarm_ok_r, alarm_ok_nxt, index_r;

    // the release of the clear input is the clearing event, not its level
    assign clr_fall = clr_prev_r & ~clr_s;

    always_comb begin
        // a new fault in the release cycle still latches
        alarm_nxt = alarm_r;
        if (alarm_event_in) begin
            alarm_nxt = 1'b1;
        end else if (clr_fall) begin
            alarm_nxt = 1'b0;
        end
        alarm_ok_nxt = ~alarm_nxt;
        drive_nxt = en_s & ~alarm_nxt;
        fwd_ok_nxt = drive_nxt & ~fwd_s;
        rev_ok_nxt = drive_nxt & ~rev_s;
        hold_nxt = drive_nxt & ~fwd_s & ~rev_s;
    end

    always_ff @(posedge core_clk or negedge alarm_clear_in_n) begin
        if (!alarm_clear_in_n) begin
            alarm_r <= 1'b0;
            clr_prev_r <= 1'b0;
            alarm_ok_r <= 1'b0;
            drive_r <= 1'b0;
            fwd_ok_r <= 1'b0;
            rev_ok_r <= 1'b0;
            hold_r <= 1'b0;
            index_r <= 1'b0;
        end else begin
            alarm_r <= alarm_nxt;
            clr_prev_r <= clr_s;
            alarm_ok_r <= alarm_ok_nxt;
            drive_r <= drive_nxt;
            fwd_ok_r <= fwd_ok_nxt;
            rev_ok_r <= rev_ok_nxt;
            hold_r <= hold_nxt;
            index_r <= z_s;
        end
    end

    // ------------------------------------------------------------------
    // position deviation counter
    // ------------------------------------------------------------------
    logic signed [DEV_W-1:0] dev_r, dev_nxt, gear_amt, dev_mag;
    logic cmd_accept, in_pos_r, in_pos_nxt;

    always_comb begin
        // commands towards a prohibited side are dropped, not deferred
        cmd_accept = en_s & ~inh_s & cmd_step & ~(cmd_fwd ? fwd_s : rev_s);
        gear_amt = signed'({{(DEV_W-PARAM_W){1'b0}}, (gear_s ? alternate_gear_param : primary_gear_param)});
        dev_nxt = dev_r;
        if (cmd_accept) begin
            dev_nxt = cmd_fwd ? dev_nxt + gear_amt : dev_nxt - gear_amt;
        end
        if (fb_step) begin
            dev_nxt = fb_fwd ? dev_nxt - DEV_W'(1) : dev_nxt + DEV_W'(1);
        end
        // a coasting motor must not build up a stale error
        if (dclr_s || !en_s) begin
            dev_nxt = SVO_DEV_RESET;
        end
        dev_mag = dev_nxt[DEV_W-1] ? -dev_nxt : dev_nxt;
        in_pos_nxt = (dev_mag <= signed'({{(DEV_W-PARAM_W){1'b0}}, in_position_param}));
    end

    always_ff @(posedge core_clk or negedge alarm_clear_in_n) begin
        if (!alarm_clear_in_n) begin
            dev_r <= SVO_DEV_RESET;
            in_pos_r <= 1'b0;
        end else begin
            dev_r <= dev_nxt;
            in_pos_r <= in_pos_nxt;
        end
    end

    // ------------------------------------------------------------------
    // divided encoder echo: fractional rate a/b, at most one step per count
    // ------------------------------------------------------------------
    logic [PARAM_W-1:0] acc_r, acc_nxt;
    logic [PARAM_W:0] acc_sum;
    logic [1:0] quad_r, quad_nxt;
    logic [1:0] echo_pins_r, echo_pins_nxt;
    logic echo_step;

    always_comb begin
        acc_sum = {1'b0, acc_r} + {1'b0, encoder_divider_a_param};
        acc_nxt = acc_r;
        quad_nxt = quad_r;
        // a zero divisor fires on every count; pass each count and hold the accumulator at reset
        echo_step = fb_step && ((encoder_divider_b_param == '0) ||
                    (acc_sum >= {1'b0, encoder_divider_b_param}));
        if (fb_step) begin
            acc_nxt = echo_step ? ((encoder_divider_b_param == '0) ? SVO_ACC_RESET :
                      PARAM_W'(acc_sum - {1'b0, encoder_divider_b_param})) : acc_sum[PARAM_W-1:0];
        end
        if (echo_step) begin
            quad_nxt = fb_fwd ? quad_r + 2'h1 : quad_r - 2'h1;
        end
        // pins get their own flops: a counter step that flips both bits must not glitch the B line
        echo_pins_nxt = {quad_nxt[1], quad_nxt[1] ^ quad_nxt[0]};
    end

    always_ff @(posedge core_clk or negedge alarm_clear_in_n) begin
        if (!alarm_clear_in_n) begin
            acc_r <= SVO_ACC_RESET;
            quad_r <= SVO_QUAD_RESET;
            echo_pins_r <= SVO_QUAD_RESET;
        end else begin
            acc_r <= acc_nxt;
            quad_r <= quad_nxt;
            echo_pins_r <= echo_pins_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign drive_enable_out = drive_r;
    assign forward_motion_ok_out = fwd_ok_r;
    assign reverse_motion_ok_out = rev_ok_r;
    assign in_position_out = in_pos_r;
    assign hold_brake_out = hold_r;
    assign alarm_ok_out = alarm_ok_r;
    assign index_open_collector_out = index_r;
    assign encoder_a_out = echo_pins_r[1];
    assign encoder_b_out = echo_pins_r[0];
    assign encoder_index_out = index_r;
    assign deviation_out = dev_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_clear_release;
        clr_s ##1 !clr_s && !alarm_event_in;
    endsequence

    chk_alarm_clear_release: assert property (@(posedge core_clk) disable iff (!alarm_clear_in_n)
        s_clear_release |=> alarm_ok_out) else $error("alarm not cleared on release");
    chk_alarm_clear_held: assert property (@(posedge core_clk) disable iff (!alarm_clear_in_n)
        (alarm_r && clr_s) |=> !alarm_ok_out) else $error("alarm cleared while clear held");
    chk_alarm_report_off: assert property (@(posedge core_clk) disable iff (!alarm_clear_in_n)
        alarm_event_in |=> !alarm_ok_out && !drive_enable_out) else $error("alarm not reported");
    chk_disable_coast: assert property (@(posedge core_clk) disable iff (!alarm_clear_in_n)
        !en_s |=> !drive_enable_out && deviation_out == 0) else $error("disabled drive still active");
    chk_brake_prohibit: assert property (@(posedge core_clk) disable iff (!alarm_clear_in_n)
        (fwd_s || rev_s || !en_s) |=> !hold_brake_out) else $error("brake output on while prohibited");
    chk_fwd_cmd_block: assert property (@(posedge core_clk) disable iff (!alarm_clear_in_n)
        (en_s && fwd_s && cmd_step && cmd_fwd && !fb_step && !dclr_s) |=> $stable(deviation_out))
        else $error("forward command passed while inhibited");
    chk_rev_cmd_block: assert property (@(posedge core_clk) disable iff (!alarm_clear_in_n)
        (en_s && rev_s && cmd_step && !cmd_fwd && !fb_step && !dclr_s) |=> $stable(deviation_out))
        else $error("reverse command passed while inhibited");
    chk_inhibit_ignore: assert property (@(posedge core_clk) disable iff (!alarm_clear_in_n)
        (inh_s && !fb_step) |=> $stable(deviation_out) || deviation_out == 0)
        else $error("command counted while pulse inhibit on");
    chk_gear_count: assert property (@(posedge core_clk) disable iff (!alarm_clear_in_n)
        (en_s && !inh_s && !dclr_s && !fwd_s && cmd_step && cmd_fwd && !fb_step)
        |=> deviation_out == $past(dev_r) + $past(gear_s ? alternate_gear_param : primary_gear_param))
        else $error("geared step miscounted");
    chk_dev_clear_zero: assert property (@(posedge core_clk) disable iff (!alarm_clear_in_n)
        dclr_s |=> deviation_out == 0 && in_position_out) else $error("deviation not cleared");
    chk_index_follow: assert property (@(posedge core_clk) disable iff (!alarm_clear_in_n)
        $rose(z_s) |=> index_open_collector_out && encoder_index_out) else $error("index not echoed");

endmodule
`default_nettype wire

// [sim/svo_ctl_model.sv]
/*
 * Motion controller model: issues one command step on request in the
 * selected pulse format and flags completion.
 * Assumes the core clock and a request held until step_done is seen.
 */
`timescale 1ns/1ps
`default_nettype none
module svo_ctl_model
    import svo_pkg::*;
(
    input wire logic core_clk,
    input wire logic alarm_clear_in_n,
    input wire logic [1:0] format_sel,
    input wire logic step_req,
    input wire logic step_fwd,
    output logic pin_a,
    output logic pin_b,
    output logic step_done
);
    logic [3:0] hold_r;
    logic [1:0] quad_r;
    logic dir_r;
    logic pa_r;
    logic pb_r;

    // quadrature pins follow the phase state, {A, A^B} counting up is forward
    assign pin_a = (format_sel == SVO_FMT_QUAD) ? quad_r[1] : pa_r;
    assign pin_b = (format_sel == SVO_FMT_QUAD) ? (quad_r[1] ^ quad_r[0]) : pb_r;

    // -------------------------------------------------------------
    // step sequencer
    // -------------------------------------------------------------
    // every phase holds at least four clocks, well above the two-clock minimum
    always_ff @(posedge core_clk or negedge alarm_clear_in_n) begin
        if (!alarm_clear_in_n) begin
            hold_r <= 4'h0;
            quad_r <= 2'h0;
            dir_r <= 1'b1;
            pa_r <= 1'b0;
            pb_r <= 1'b0;
            step_done <= 1'b0;
        end else begin
            step_done <= (hold_r == 4'h1);
            if (hold_r != 4'h0) begin
                hold_r <= hold_r - 4'h1;
            end else if (step_req && !step_done) begin
                hold_r <= 4'hC;
                dir_r <= step_fwd;
                if (format_sel == SVO_FMT_PULSE_SIGN) begin
                    pb_r <= step_fwd; // sign settles before the pulse edge
                end
            end
            if (hold_r == 4'h9) begin
                case (format_sel)
                    SVO_FMT_PULSE_SIGN: pa_r <= 1'b1;
                    SVO_FMT_FWD_REV: begin
                        if (dir_r) pa_r <= 1'b1;
                        else pb_r <= 1'b1;
                    end
                    SVO_FMT_QUAD: quad_r <= dir_r ? quad_r + 2'h1 : quad_r - 2'h1;
                    default: ;
                endcase
            end
            if (hold_r == 4'h5 && format_sel != SVO_FMT_QUAD) begin
                pa_r <= 1'b0;
                if (format_sel == SVO_FMT_FWD_REV) pb_r <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [sim/test_svo_io_logic.sv]
/*
 * Bench for the servo I/O logic: drives pins, steps the controller model
 * and compares outputs against a running deviation estimate.
 * Assumes one core clock; gear and window values fixed below.
 */
`timescale 1ns/1ps
`default_nettype none
module test_svo_io_logic
    import svo_pkg::*;
;
    localparam logic [SVO_PARAM_W-1:0] GEAR_PRI = 16'h0003;
    localparam logic [SVO_PARAM_W-1:0] GEAR_ALT = 16'h0005;
    localparam logic [SVO_PARAM_W-1:0] INPOS_WIN = 16'h0004;
    logic core_clk = 1'b0;
    logic alarm_clear_in_n = 1'b0;
    logic servo_enable_in, alarm_clear_in, forward_inhibit_in, reverse_inhibit_in, deviation_clear_in;
    logic pulse_inhibit_in, gear_select_in, encoder_z_in, alarm_event_in, step_req, step_fwd;
    logic [1:0] fmt, e_s, echo_prev;
    wire encoder_a_in = e_s[1];
    wire encoder_b_in = e_s[1] ^ e_s[0];
    logic cmd_a, cmd_b, step_done, drive_enable_out, fwd_ok, rev_ok, in_position_out;
    logic hold_brake_out, alarm_ok_out, index_oc, enc_a_o, enc_b_o, enc_z_o;
    logic signed [SVO_DEV_W-1:0] deviation_out, exp_dev;
    int err_total = 0;
    int tests_run = 0;
    int echo_moves = 0;
    int n0;

    always #12.5 core_clk = ~core_clk;

    svo_ctl_model u_svo_ctl_model (.core_clk(core_clk), .alarm_clear_in_n(alarm_clear_in_n), .format_sel(fmt), .step_req(step_req),
        .step_fwd(step_fwd), .pin_a(cmd_a), .pin_b(cmd_b), .step_done(step_done));

    svo_io_logic u_svo_io_logic (.core_clk(core_clk), .alarm_clear_in_n(alarm_clear_in_n), .servo_enable_in(servo_enable_in),
        .alarm_clear_in(alarm_clear_in), .forward_inhibit_in(forward_inhibit_in),
        .reverse_inhibit_in(reverse_inhibit_in), .deviation_clear_in(deviation_clear_in),
        .pulse_inhibit_in(pulse_inhibit_in), .gear_select_in(gear_select_in), .command_pulse_in(cmd_a),
        .command_sign_in(cmd_b), .encoder_a_in(encoder_a_in), .encoder_b_in(encoder_b_in),
        .encoder_z_in(encoder_z_in), .alarm_event_in(alarm_event_in), .pulse_format_param(fmt),
        .primary_gear_param(GEAR_PRI), .alternate_gear_param(GEAR_ALT), .in_position_param(INPOS_WIN),
        .encoder_divider_a_param(16'h0001), .encoder_divider_b_param(16'h0002),
        .drive_enable_out(drive_enable_out), .forward_motion_ok_out(fwd_ok), .reverse_motion_ok_out(rev_ok),
        .in_position_out(in_position_out), .hold_brake_out(hold_brake_out), .alarm_ok_out(alarm_ok_out),
        .index_open_collector_out(index_oc), .encoder_a_out(enc_a_o), .encoder_b_out(enc_b_o),
        .encoder_index_out(enc_z_o), .deviation_out(deviation_out));

    // count echo state moves; moves are judged after the eight forward and again after the two reverse counts, the echo state once after the reverse ones
    always @(posedge core_clk) begin
        if ({enc_a_o, enc_b_o} != echo_prev) echo_moves <= echo_moves + 1;
        echo_prev <= {enc_a_o, enc_b_o};
    end

    // -------------------------------------------------------------
    // tasks
    // -------------------------------------------------------------
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // waits past the edge so registered outputs have landed
    task automatic settle(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // in-position is judged from the expected deviation, never the observed one
    task automatic chk_dev();
        tests_run++;
        if (deviation_out !== exp_dev) begin
            err_total++;
            $display("CHECK FAILED at %0t: deviation %0d expected %0d", $time, deviation_out, exp_dev);
        end
        chk_bit(in_position_out, ((exp_dev < 0) ? -exp_dev : exp_dev) <= INPOS_WIN, "in position");
    endtask

    task automatic do_step(input logic fwd, input logic counted);
        int n;
        int g;
        g = gear_select_in ? 5 : 3;
        @(posedge core_clk);
        step_req <= 1'b1;
        step_fwd <= fwd;
        n = 0;
        while (step_done !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            n++;
        end
        step_req <= 1'b0;
        if (n >= 40) begin
            err_total++;
            $display("CHECK FAILED at %0t: controller step hung", $time);
            close_out();
        end
        if (counted) exp_dev += fwd ? g : -g;
        settle(4);
    endtask

    // one feedback count in either direction, each phase held four clocks
    task automatic enc_step(input logic fwd);
        @(posedge core_clk);
        e_s <= fwd ? e_s + 2'h1 : e_s - 2'h1;
        exp_dev += fwd ? -1 : 1;
        settle(3);
    endtask

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        {servo_enable_in, alarm_clear_in, forward_inhibit_in, reverse_inhibit_in} = 4'h0;
        {deviation_clear_in, pulse_inhibit_in, gear_select_in, encoder_z_in, alarm_event_in} = 5'h00;
        {step_req, step_fwd} = 2'h0;
        fmt = SVO_FMT_PULSE_SIGN;
        e_s = 2'h0;
        exp_dev = 32'h0000_0000;
        repeat (5) @(posedge core_clk);
        alarm_clear_in_n <= 1'b1;
        settle(4);
        chk_bit(alarm_ok_out, 1'b1, "alarm ok");
        chk_bit(drive_enable_out, 1'b0, "drive enable");
        chk_bit(hold_brake_out, 1'b0, "hold brake");
        do_step(1'b1, 1'b0);
        chk_dev();
        @(posedge core_clk);
        servo_enable_in <= 1'b1;
        settle(4);
        chk_bit(drive_enable_out, 1'b1, "drive enable");
        chk_bit(hold_brake_out, 1'b1, "hold brake");
        // every pulse format, alternate gear on the middle one
        for (int f = 0; f < 3; f++) begin
            @(posedge core_clk);
            fmt <= f[1:0];
            gear_select_in <= f[0];
            settle(4);
            do_step(1'b1, 1'b1);
            do_step(1'b1, 1'b1);
            do_step(1'b0, 1'b1);
            chk_dev();
        end
        // forward inhibit, reverse inhibit, then pulse inhibit
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            forward_inhibit_in <= (i == 0);
            reverse_inhibit_in <= (i == 1);
            pulse_inhibit_in <= (i == 2);
            settle(4);
            chk_bit(fwd_ok, i != 0, "forward ok");
            chk_bit(rev_ok, i != 1, "reverse ok");
            chk_bit(hold_brake_out, i == 2, "hold brake");
            do_step(1'b1, i == 1);
            do_step(1'b0, i == 0);
            chk_dev();
        end
        @(posedge core_clk);
        pulse_inhibit_in <= 1'b0;
        n0 = echo_moves;
        repeat (8) enc_step(1'b1);
        settle(4);
        chk_dev();
        chk_bit(echo_moves - n0 == 4, 1'b1, "echo moves");
        // two reverse counts leave the window and step the echo back by one state
        repeat (2) enc_step(1'b0);
        settle(4);
        chk_dev();
        chk_bit(echo_moves - n0 == 5, 1'b1, "echo moves");
        chk_bit({enc_a_o, enc_b_o} == 2'h2, 1'b1, "echo state");
        @(posedge core_clk);
        encoder_z_in <= 1'b1;
        settle(4);
        chk_bit(index_oc, 1'b1, "index oc");
        chk_bit(enc_z_o, 1'b1, "index echo");
        @(posedge core_clk);
        encoder_z_in <= 1'b0;
        settle(4);
        chk_bit(index_oc, 1'b0, "index oc");
        chk_bit(enc_z_o, 1'b0, "index echo");
        @(posedge core_clk);
        deviation_clear_in <= 1'b1;
        settle(4);
        exp_dev = 32'h0000_0000;
        chk_dev();
        @(posedge core_clk);
        deviation_clear_in <= 1'b0;
        alarm_event_in <= 1'b1;
        @(posedge core_clk);
        alarm_event_in <= 1'b0;
        settle(2);
        chk_bit(alarm_ok_out, 1'b0, "alarm ok");
        chk_bit(hold_brake_out, 1'b0, "hold brake");
        @(posedge core_clk);
        alarm_clear_in <= 1'b1;
        settle(5);
        chk_bit(alarm_ok_out, 1'b0, "alarm ok");
        @(posedge core_clk);
        alarm_clear_in <= 1'b0;
        settle(5);
        chk_bit(alarm_ok_out, 1'b1, "alarm ok");
        chk_bit(hold_brake_out, 1'b1, "hold brake");
        do_step(1'b1, 1'b1);
        chk_dev();
        @(posedge core_clk);
        servo_enable_in <= 1'b0;
        settle(4);
        exp_dev = 32'h0000_0000;
        chk_bit(drive_enable_out, 1'b0, "drive enable");
        chk_dev();
        close_out();
    end
endmodule
`default_nettype wire
